// *** design/fault_qual_params.svh ***
// Register offsets, field positions, reset values and timing counts of the fault qualifier.
`ifndef FAULT_QUAL_PARAMS_SVH
`define FAULT_QUAL_PARAMS_SVH

// ==========================================================================
// Register offsets
`define CFC_ADDR 8'h22
`define THRESH_ADDR 8'h23
`define STATUS_ADDR 8'h24
`define MASK_ADDR 8'h25
`define MODE_ADDR 8'h26
`define ERR_ADDR 8'h27

// ==========================================================================
// Field positions of the consecutive fault count control register
`define CFC_TIMEOUT_BIT 7
`define CFC_CRIT_HI 6
`define CFC_CRIT_LO 4
`define CFC_EVT_HI 3
`define CFC_EVT_LO 1
`define CFC_RESET 8'h70
`define CFC_WMASK 8'hfe

// ==========================================================================
// Bus clock low timeout
`define TIMEOUT_MS 30
`define CLK_HZ 25000000
`define TIMEOUT_CYCLES ((`TIMEOUT_MS * `CLK_HZ) / 1000)

`endif

// *** design/fault_qual_pkg.sv ***
// Types shared by the fault qualifier design files.
package fault_qual_pkg;

   // One conversion result of one channel, a raw temperature and diode fault flag; the qualifier compares it.
   typedef struct packed {
      logic [7:0] temp;
      logic diode_fault;
   } meas_t;

   // Limits applied to one channel.
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic [7:0] crit;
   } limits_t;

   // Event output drive style.
   typedef enum logic {
      MODE_INTERRUPT,
      MODE_COMPARATOR
   } event_mode_t;

endpackage

// *** design/chan_qualifier.sv ***
// One channel of consecutive fault and critical limit qualification.
`include "fault_qual_params.svh"

module chan_qualifier
   import fault_qual_pkg::*;
#(
   parameter int CNT_W = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Measurement
   input wire logic meas_valid,
   input wire meas_t meas,
   input wire limits_t lim,
   input wire logic [7:0] hyst,
   // Configuration
   input wire event_mode_t mode,
   input wire logic [CNT_W-1:0] evt_need,
   input wire logic [CNT_W-1:0] crit_need,
   // Results
   output logic evt_fire,
   output logic evt_level,
   output logic crit_level,
   output logic [1:0] err_bits,
   output logic [CNT_W-1:0] evt_cnt,
   output logic [CNT_W-1:0] crit_cnt
);

   // Elaboration check: the counters must be able to hold a threshold of four.
   if (CNT_W < 3) begin : g_cnt_w_check
      $error("CNT_W too small for a threshold of four");
   end

   logic high_viol, low_viol, bad_int, bad_cmp, below_hyst, crit_over, below_crit_hyst;
   logic [CNT_W-1:0] evt_cnt_q, evt_cnt_d, crit_cnt_q;
   logic evt_level_q, crit_level_q, evt_fire_q;
   logic [1:0] err_q;
   logic [8:0] hi_minus_h, crit_minus_h;

   // Limit comparisons; hysteresis thresholds are signed-safe by a guard bit.
   assign high_viol = meas.temp > lim.high;
   assign low_viol = meas.temp <= lim.low;
   assign bad_int = high_viol | low_viol | meas.diode_fault;
   assign bad_cmp = high_viol;
   assign hi_minus_h = {1'b0, lim.high} - {1'b0, hyst};
   assign crit_minus_h = {1'b0, lim.crit} - {1'b0, hyst};
   assign below_hyst = !hi_minus_h[8] && ({1'b0, meas.temp} < hi_minus_h);
   assign crit_over = meas.temp > lim.crit;
   assign below_crit_hyst = !crit_minus_h[8] && ({1'b0, meas.temp} < crit_minus_h);

   // Next event count for the current mode.
   always_comb begin
      evt_cnt_d = evt_cnt_q;
      if (mode == MODE_INTERRUPT) begin
         if (!bad_int) evt_cnt_d = '0;
         else if (evt_cnt_q + 1'b1 >= evt_need) evt_cnt_d = '0;
         else evt_cnt_d = evt_cnt_q + 1'b1;
      end else begin
         if (evt_level_q) begin
            if (below_hyst) evt_cnt_d = '0;
         end else if (!bad_cmp) evt_cnt_d = '0;
         else if (evt_cnt_q < evt_need) evt_cnt_d = evt_cnt_q + 1'b1;
      end
   end

   // Event counter and comparator level; counters only move on a result.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         evt_cnt_q <= '0;
         evt_level_q <= 1'b0;
         evt_fire_q <= 1'b0;
         err_q <= 2'h0;
      end else begin
         evt_fire_q <= 1'b0;
         if (meas_valid) begin
            evt_cnt_q <= evt_cnt_d;
            if (mode == MODE_INTERRUPT) begin
               evt_level_q <= 1'b0;
               if (bad_int && (evt_cnt_q + 1'b1 >= evt_need)) begin
                  evt_fire_q <= 1'b1;
                  err_q <= {high_viol, low_viol | meas.diode_fault};
               end
            end else if (evt_level_q) begin
               if (below_hyst) evt_level_q <= 1'b0;
            end else if (bad_cmp && (evt_cnt_q + 1'b1 >= evt_need)) begin
               evt_level_q <= 1'b1;
               err_q <= 2'h2;
            end
         end
      end
   end

   // Critical counter and level; the level holds until below limit minus hysteresis.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         crit_cnt_q <= '0;
         crit_level_q <= 1'b0;
      end else if (meas_valid) begin
         if (crit_level_q) begin
            if (below_crit_hyst) begin
               crit_cnt_q <= '0;
               crit_level_q <= 1'b0;
            end
         end else if (!crit_over) begin
            crit_cnt_q <= '0;
         end else if (crit_cnt_q + 1'b1 >= crit_need) begin
            crit_cnt_q <= crit_need;
            crit_level_q <= 1'b1;
         end else begin
            crit_cnt_q <= crit_cnt_q + 1'b1;
         end
      end
   end

   assign evt_fire = evt_fire_q;
   assign evt_level = evt_level_q;
   assign crit_level = crit_level_q;
   assign err_bits = err_q;
   assign evt_cnt = evt_cnt_q;
   assign crit_cnt = crit_cnt_q;

endmodule // chan_qualifier

// *** design/consecutive_fault_qualifier.sv ***
// Top level of the two-channel consecutive fault qualifier with its register port.
//
// The address-and-strobe port was left to the implementer.
`include "fault_qual_params.svh"

module consecutive_fault_qualifier
   import fault_qual_pkg::*;
#(
   parameter int NCH = 2,
   parameter int TIMEOUT_CYC = `TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Conversion results, one valid strobe per channel
   input wire logic [NCH-1:0] meas_valid,
   input wire meas_t [NCH-1:0] meas,
   input wire limits_t [NCH-1:0] lim,
   input wire logic [7:0] hyst,
   // Serial bus clock line and protocol reset
   input wire logic bus_clock_line,
   output logic bus_proto_reset,
   // Event pin, open drain, active low
   output logic event_n_o,
   output logic event_n_oe,
   // Critical pin, active low
   output logic crit_n,
   // Interrupt
   output logic irq
);

   // Elaboration checks: the status and mask bytes hold at most eight channels; the error byte holds four.
   if (NCH < 1 || NCH > 8) begin : g_nch_check
      $error("NCH must be 1 to 8");
   end
   if (TIMEOUT_CYC < 1) begin : g_timeout_check
      $error("TIMEOUT_CYC must be positive");
   end

   // ========================================================================
   // Registers

   logic [7:0] cfc_q, mask_q, irq_mask_q, rdata_q;
   logic [NCH-1:0] status_q;
   logic [1:0] err_q [NCH];
   event_mode_t mode_q;
   logic [2:0] evt_need, crit_need;
   logic [NCH-1:0] fire, lvl, clvl;
   logic [1:0] eb [NCH];
   logic [7:0] err_flat;
   logic status_rd;

   // Field decode: one plus the number of set bits, which covers undocumented codes.
   function automatic logic [2:0] need_of(input logic [2:0] f);
      need_of = 3'h1 + {2'h0, f[0]} + {2'h0, f[1]} + {2'h0, f[2]};
   endfunction

   assign evt_need = need_of(cfc_q[`CFC_EVT_HI:`CFC_EVT_LO]);
   assign crit_need = need_of(cfc_q[`CFC_CRIT_HI:`CFC_CRIT_LO]);

   // Configuration registers; bit 0 of the count register is never stored.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfc_q <= `CFC_RESET;
         mask_q <= 8'h00;
         irq_mask_q <= 8'h00;
         mode_q <= MODE_INTERRUPT;
      end else if (reg_wr) begin
         case (reg_addr)
            `CFC_ADDR: cfc_q <= reg_wdata & `CFC_WMASK;
            `MASK_ADDR: mask_q <= reg_wdata;
            `THRESH_ADDR: irq_mask_q <= reg_wdata;
            `MODE_ADDR: mode_q <= reg_wdata[0] ? MODE_COMPARATOR : MODE_INTERRUPT;
            default: ;
         endcase
      end
   end

   // ========================================================================
   // Channels; each owns its counters so a trigger on one leaves the others alone.
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : ch
         chan_qualifier #(.CNT_W(3)) u_q (
            .mclk(mclk),
            .arst_n(arst_n),
            .meas_valid(meas_valid[g]),
            .meas(meas[g]),
            .lim(lim[g]),
            .hyst(hyst),
            .mode(mode_q),
            .evt_need(evt_need),
            .crit_need(crit_need),
            .evt_fire(fire[g]),
            .evt_level(lvl[g]),
            .crit_level(clvl[g]),
            .err_bits(eb[g]),
            .evt_cnt(),
            .crit_cnt()
         );
      end
   endgenerate

   // ========================================================================
   // Status: a fired channel sets its sticky bit; a read clears, but a set wins.
   assign status_rd = reg_rd && (reg_addr == `STATUS_ADDR);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (fire[i] || (mode_q == MODE_COMPARATOR && lvl[i])) status_q[i] <= 1'b1;
            else if (status_rd) status_q[i] <= 1'b0;
         end
      end
   end

   // Last error condition per channel: bit 1 high, bit 0 low or fault.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NCH; i++) err_q[i] <= 2'h0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (fire[i] || lvl[i]) err_q[i] <= eb[i];
         end
      end
   end

   always_comb begin
      err_flat = 8'h00;
      for (int i = 0; i < NCH && i < 4; i++) begin
         err_flat[2*i +: 2] = err_q[i];
      end
   end

   // ========================================================================
   // Read port; data stand in the cycle after the strobe only.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `CFC_ADDR: rdata_q <= cfc_q & `CFC_WMASK;
            `MASK_ADDR: rdata_q <= mask_q;
            `THRESH_ADDR: rdata_q <= irq_mask_q;
            `STATUS_ADDR: rdata_q <= 8'(status_q);
            `MODE_ADDR: rdata_q <= {7'h00, mode_q == MODE_COMPARATOR};
            `ERR_ADDR: rdata_q <= err_flat;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   // ========================================================================
   // Event pin. Interrupt mode latches on the sticky status; comparator mode
   // follows each channel's level. Masking gates only this pin.
   logic [NCH-1:0] evt_src;
   logic event_q, crit_q;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         evt_src[i] = (mode_q == MODE_INTERRUPT ? status_q[i] : lvl[i]) & ~mask_q[i];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         event_q <= 1'b0;
         crit_q <= 1'b0;
      end else begin
         event_q <= |evt_src;
         crit_q <= |clvl;
      end
   end

   assign event_n_o = 1'b0;
   assign event_n_oe = event_q;
   assign crit_n = ~crit_q;
   assign irq = |(status_q & irq_mask_q[NCH-1:0]);

   // ========================================================================
   // Bus clock low timeout. A plain counter; it never runs while disabled.
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   logic [TW-1:0] low_cnt_q;
   logic proto_rst_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_q <= '0;
         proto_rst_q <= 1'b0;
      end else begin
         proto_rst_q <= 1'b0;
         if (!cfc_q[`CFC_TIMEOUT_BIT] || bus_clock_line) begin
            low_cnt_q <= '0;
         end else if (low_cnt_q == TW'(TIMEOUT_CYC)) begin
            proto_rst_q <= 1'b1;
            low_cnt_q <= '0;
         end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
         end
      end
   end

   assign bus_proto_reset = proto_rst_q;

endmodule // consecutive_fault_qualifier

// *** dv/conv_model.sv ***
// Behavioural model of the conversion engine and serial bus host feeding the qualifier.
module conv_model
   import fault_qual_pkg::*;
#(
   parameter int NCH = 2
) (
   // Clock
   input wire logic mclk,
   // Conversion results
   output logic [NCH-1:0] meas_valid,
   output meas_t [NCH-1:0] meas,
   // Serial bus clock and the protocol reset it may provoke
   output logic bus_clock_line,
   input wire logic bus_proto_reset
);
   timeunit 1ns;
   timeprecision 1ps;

   // ======================================================
   // Idle state: bus clock pulled high, no result offered.
   initial begin
      meas_valid = '0;
      meas = '0;
      bus_clock_line = 1'b1;
   end

   // ======================================================
   // One result on each selected channel, a single-cycle strobe; afterwards the data
   // bus carries the inverse so that a stale sample can never pass for a fresh one.
   task automatic convert(input logic [NCH-1:0] vld, input meas_t m0, input meas_t m1);
      @(posedge mclk);
      meas_valid <= vld;
      meas <= {m1, m0};
      @(posedge mclk);
      meas_valid <= '0;
      meas <= ~{m1, m0};
   endtask

   // Holds the bus clock low for n plus one cycles and counts protocol resets over the first n.
   task automatic hold_low(input int n, output int pulses);
      pulses = 0;
      @(posedge mclk);
      bus_clock_line <= 1'b0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (bus_proto_reset === 1'b1) pulses++;
      end
      @(posedge mclk);
      bus_clock_line <= 1'b1;
   endtask
endmodule // conv_model

// *** dv/consecutive_fault_qualifier_checker.sv ***
// Port-level assertions of the consecutive fault qualifier.
`include "fault_qual_params.svh"

module consecutive_fault_qualifier_checker #(
   parameter int NCH = 2,
   parameter int TIMEOUT_CYC = 20
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Measurements, bus timeout and pins
   input wire logic [NCH-1:0] meas_valid,
   input wire logic bus_clock_line,
   input wire logic bus_proto_reset,
   input wire logic event_n_o,
   input wire logic event_n_oe,
   input wire logic crit_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int lo_cnt_q;

   // ======================================================
   // Length of the current low stretch, saturated so it never wraps.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lo_cnt_q <= 0;
      end else if (bus_clock_line) begin
         lo_cnt_q <= 0;
      end else if (lo_cnt_q < 1000) begin
         lo_cnt_q <= lo_cnt_q + 1;
      end
   end

   // ======================================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   sequence rd_cfc_s;
      reg_rd && reg_addr == `CFC_ADDR;
   endsequence
   sequence rd_hole_s;
      reg_rd && reg_addr > `ERR_ADDR;
   endsequence

   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   cfc_bit0_a: assert property (rd_cfc_s |=> reg_rdata[0] == 1'b0)
      else $error("count register bit 0 reads one");
   hole_zero_a: assert property (rd_hole_s |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   tmo_single_a: assert property (bus_proto_reset |=> !bus_proto_reset)
      else $error("protocol reset too long");
   tmo_cause_a: assert property (bus_proto_reset |-> $past(lo_cnt_q) >= TIMEOUT_CYC)
      else $error("protocol reset before timeout");
   evt_cause_a: assert property ($rose(event_n_oe) |->
      $past(|meas_valid, 2) || $past(|meas_valid, 3) || $past(reg_wr, 2))
      else $error("event without measurement or register write");
   evt_drop_a: assert property ($fell(event_n_oe) |->
      $past(reg_rd, 2) || $past(|meas_valid, 2) || $past(reg_wr, 2))
      else $error("event release without read, measurement or write");
   crit_cause_a: assert property ($changed(crit_n) |-> $past(|meas_valid, 2))
      else $error("critical change without measurement");
   pin_low_a: assert property (event_n_o == 1'b0)
      else $error("event pin drives high");
endmodule // consecutive_fault_qualifier_checker

bind consecutive_fault_qualifier consecutive_fault_qualifier_checker #(
   .NCH(NCH), .TIMEOUT_CYC(TIMEOUT_CYC)
) consecutive_fault_qualifier_checker_inst (
   .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .meas_valid(meas_valid), .bus_clock_line(bus_clock_line),
   .bus_proto_reset(bus_proto_reset), .event_n_o(event_n_o), .event_n_oe(event_n_oe),
   .crit_n(crit_n)
);

// *** dv/consecutive_fault_qualifier_tb.sv ***
// Self-checking testbench of the consecutive fault qualifier.
`include "fault_qual_params.svh"

module consecutive_fault_qualifier_tb
   import fault_qual_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam meas_t CLEAN = {8'h30, 1'b0};
   localparam meas_t OVER = {8'h51, 1'b0};
   meas_t bad [3] = '{{8'h47, 1'b0}, {8'h10, 1'b0}, {8'h30, 1'b1}};
   logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b011, 3'b111, 3'b101};
   int need [5] = '{1, 2, 3, 4, 3};
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] meas_valid;
   meas_t [1:0] meas;
   limits_t [1:0] lim = {2{8'h46, 8'h10, 8'h50}};
   logic bus_clock_line;
   logic bus_proto_reset;
   logic event_n_oe;
   logic crit_n;
   logic irq;
   int errors = 0;
   int check_count = 0;

   always #20 mclk = ~mclk;

   consecutive_fault_qualifier #(.NCH(2), .TIMEOUT_CYC(20)) consecutive_fault_qualifier_inst (
      .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
      .meas(meas), .lim(lim), .hyst(8'h05), .bus_clock_line(bus_clock_line),
      .bus_proto_reset(bus_proto_reset), .event_n_o(), .event_n_oe(event_n_oe),
      .crit_n(crit_n), .irq(irq)
   );
   conv_model #(.NCH(2)) conv_model_inst (
      .mclk(mclk), .meas_valid(meas_valid), .meas(meas),
      .bus_clock_line(bus_clock_line), .bus_proto_reset(bus_proto_reset)
   );

   // ======================================================
   // Shared bus cycles and comparison; a flag is widened so an unknown still fails.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // Feeds n results to channel 0, then lets the two-edge output latency pass.
   task automatic go(input int n, input meas_t m);
      repeat (n) conv_model_inst.convert(2'b01, m, CLEAN);
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // ======================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] d;
      rd(`CFC_ADDR, d);
      chk(d, 8'h70);
      chk(crit_n, 1'b1);
      wr(`CFC_ADDR, 8'hff);
      rd(`CFC_ADDR, d);
      chk(d, 8'hfe);
      rd(8'h3c, d);
      chk(d, 8'h00);
      $display("test regs done");
   endtask
   // Count codes for one to four samples in interrupt mode; a clean sample at exactly the high limit
   // between two short runs must restart the count.
   task automatic t_event_count();
      logic [7:0] d;
      wr(`MASK_ADDR, 8'h00);
      wr(8'h23, 8'h01);
      foreach (codes[i]) begin
         wr(`CFC_ADDR, {4'h7, codes[i], 1'b0});
         go(need[i] - 1, bad[i % 3]);
         go(1, {8'h46, 1'b0});
         go(need[i] - 1, bad[i % 3]);
         chk(event_n_oe, 1'b0);
         go(1, bad[i % 3]);
         chk(event_n_oe, 1'b1);
         chk(irq, 1'b1);
         rd(`STATUS_ADDR, d);
         chk(d, 8'h01);
         go(0, CLEAN);
         chk(event_n_oe, 1'b0);
         chk(irq, 1'b0);
      end
      $display("test event_count done");
   endtask
   // Channel 1 keeps its partial count while channel 0 triggers and clears.
   task automatic t_hold_other();
      logic [7:0] d;
      wr(`CFC_ADDR, 8'h72);
      wr(8'h23, 8'h02);
      conv_model_inst.convert(2'b11, bad[0], bad[0]);
      go(1, bad[0]);
      chk(irq, 1'b0);
      rd(`STATUS_ADDR, d);
      chk(d, 8'h01);
      conv_model_inst.convert(2'b11, bad[0], bad[0]);
      go(0, CLEAN);
      chk(irq, 1'b1);
      rd(`STATUS_ADDR, d);
      chk(d, 8'h02);
      rd(`ERR_ADDR, d);
      chk({6'h00, d[3:2]}, 8'h02);
      $display("test hold_other done");
   endtask
   // Comparator mode counts only high samples and releases below high minus hysteresis.
   task automatic t_comparator();
      logic [7:0] d;
      go(1, CLEAN);
      wr(`MODE_ADDR, 8'h01);
      go(1, bad[1]);
      go(1, bad[2]);
      go(1, bad[0]);
      chk(event_n_oe, 1'b0);
      go(1, bad[0]);
      chk(event_n_oe, 1'b1);
      go(1, {8'h42, 1'b0});
      chk(event_n_oe, 1'b1);
      go(1, {8'h40, 1'b0});
      chk(event_n_oe, 1'b0);
      wr(`MODE_ADDR, 8'h00);
      rd(`STATUS_ADDR, d);
      chk(d, 8'h01);
      $display("test comparator done");
   endtask
   // Critical output for count codes of one to four samples, with the event path masked throughout.
   task automatic t_critical();
      logic [7:0] d;
      wr(`MASK_ADDR, 8'h01);
      foreach (codes[i]) begin
         wr(`CFC_ADDR, {1'b0, codes[i], 4'h0});
         go(need[i] - 1, OVER);
         go(1, {8'h4f, 1'b0});
         go(need[i] - 1, OVER);
         chk(crit_n, 1'b1);
         go(1, OVER);
         chk(crit_n, 1'b0);
         chk(event_n_oe, 1'b0);
         go(1, {8'h4c, 1'b0});
         chk(crit_n, 1'b0);
         go(1, {8'h4a, 1'b0});
         chk(crit_n, 1'b1);
      end
      rd(`STATUS_ADDR, d);
      chk(d, 8'h01);
      $display("test critical done");
   endtask
   // A long low bus clock is harmless while the timeout is off and resets once when on.
   task automatic t_timeout();
      int p;
      conv_model_inst.hold_low(40, p);
      chk(p[7:0], 8'h00);
      wr(`CFC_ADDR, 8'hf0);
      conv_model_inst.hold_low(40, p);
      chk(p[7:0], 8'h01);
      $display("test timeout done");
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ======================================================
   // Main sequence and run limit.
   initial begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      t_regs();
      t_event_count();
      t_hold_other();
      t_comparator();
      t_critical();
      t_timeout();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
      summarize();
   end
endmodule // consecutive_fault_qualifier_tb
